/* src/sse_exec.sv */
// execution unit for skip-on-test and subtract instructions
// Function
// RL1: acc gets mem plus one, skip if zero
// RL2: increment-skip leaves memory byte untouched
// RL3: skip when selected memory bit is one
// RL4: each skip costs two cycles, dummy inserted
// RL5: nonzero skip rewrites byte, skips if nonzero
// RL6: subtract memory from acc into acc
// RL7: carry cleared on borrow, else set
// RL8: subtract to memory, acc unchanged
// RL9: subtract immediate from acc into acc
// RL10: subtracts update all six flags; skips none
// RL11: zero, overflow, aux carry follow conventions
`timescale 1ns/10ps
`default_nettype none
module sse_exec (
    input wire logic core_clk, // instruction clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic issue, // one-cycle pulse: execute op
    input wire logic [4:0] op, // operation select
    input wire logic [7:0] mem_rdata, // addressed data memory byte
    input wire logic [7:0] imm, // immediate from instruction word
    input wire logic [2:0] bit_sel, // bit index for bit test
    output logic [7:0] accumulator, // accumulator
    output logic mem_we, // data memory write strobe
    output logic [7:0] mem_wdata, // data memory write value
    output logic skip, // pulse: next instruction skipped
    output logic dummy, // high during inserted dummy cycle
    output logic busy, // high while a skip-class op occupies cycle two
    output logic overflow_flag, // overflow
    output logic zero_flag, // zero
    output logic aux_carry_flag, // auxiliary carry
    output logic carry_flag, // carry
    output logic signed_compare_flag, // signed compare
    output logic combined_zero_flag // combined zero
);
    typedef struct packed {
        sse_pkg::sse_state_e st;
        logic [7:0] acc;
        logic we;
        logic [7:0] wdata;
        logic skip;
        logic busy;
        logic dum;
        logic ov;
        logic z;
        logic ac;
        logic c;
        logic sc;
        logic cz;
    } sse_state_s;

    sse_state_s cur_r;
    sse_state_s cur_nxt;

    logic [7:0] sub_b;
    logic [7:0] diff;
    logic f_c;
    logic f_ac;
    logic f_ov;
    logic f_z;
    logic f_sc;
    logic f_cz;
    logic [7:0] inc_val;
    logic accept;

    function automatic logic is_sub(input logic [4:0] o);
        return (o == sse_pkg::SSE_OP_SUB_ACC) || (o == sse_pkg::SSE_OP_SUB_MEM)
               || (o == sse_pkg::OP_SUB_IMM);
    endfunction : is_sub

    // RL9 immediate operand
    assign sub_b = (op == sse_pkg::OP_SUB_IMM) ? imm : mem_rdata;

    // RL11 flag arithmetic
    sse_sub_flags u_sub (
        .minuend(cur_r.acc),
        .subtrahend(sub_b),
        .diff(diff),
        .carry(f_c),
        .aux_carry(f_ac),
        .overflow(f_ov),
        .zero(f_z),
        .signed_compare(f_sc),
        .combined_zero(f_cz)
    );

    // an issue during the dummy cycle is ignored; the fetch stage is stalled by busy
    assign accept = issue && (cur_r.st == sse_pkg::SSE_ST_IDLE);

    always_comb begin
        inc_val = mem_rdata + sse_pkg::ONE;
        cur_nxt = cur_r;
        cur_nxt.we = 1'b0;
        cur_nxt.wdata = sse_pkg::ZERO;
        cur_nxt.skip = 1'b0;
        cur_nxt.busy = 1'b0;
        cur_nxt.dum = 1'b0;
        case (cur_r.st)
            sse_pkg::SSE_ST_IDLE: begin
                if (accept) begin
                    case (op)
                        sse_pkg::SSE_OP_INC_SKIP_ACC: begin
                            // RL1 increment into acc
                            cur_nxt.acc = inc_val;
                            // RL2 no memory write here
                            cur_nxt.skip = (inc_val == sse_pkg::ZERO);
                        end
                        sse_pkg::SSE_OP_SKIP_BIT: begin
                            // RL3 bit test
                            cur_nxt.skip = mem_rdata[bit_sel];
                        end
                        sse_pkg::SSE_OP_SKIP_NONZERO: begin
                            // RL5 write back and test
                            cur_nxt.we = 1'b1;
                            cur_nxt.wdata = mem_rdata;
                            cur_nxt.skip = (mem_rdata != sse_pkg::ZERO);
                        end
                        sse_pkg::SSE_OP_SUB_ACC, sse_pkg::OP_SUB_IMM: begin
                            // RL6 difference into acc
                            cur_nxt.acc = diff;
                        end
                        sse_pkg::SSE_OP_SUB_MEM: begin
                            // RL8 difference to memory
                            cur_nxt.we = 1'b1;
                            cur_nxt.wdata = diff;
                        end
                        default: begin
                            cur_nxt.skip = 1'b0;
                        end
                    endcase
                    // RL10 only subtracts touch flags
                    if (is_sub(op)) begin
                        cur_nxt.ov = f_ov;
                        cur_nxt.z = f_z;
                        cur_nxt.ac = f_ac;
                        // RL7 carry from borrow
                        cur_nxt.c = f_c;
                        cur_nxt.sc = f_sc;
                        cur_nxt.cz = f_cz;
                    end
                    // RL4 second cycle for any skip-class op
                    if (op == sse_pkg::SSE_OP_INC_SKIP_ACC || op == sse_pkg::SSE_OP_SKIP_BIT
                        || op == sse_pkg::SSE_OP_SKIP_NONZERO) begin
                        cur_nxt.st = sse_pkg::SSE_ST_DUMMY;
                        // kept as flops so busy and dummy leave glitch-free
                        cur_nxt.busy = 1'b1;
                        cur_nxt.dum = cur_nxt.skip;
                    end
                end
            end
            sse_pkg::SSE_ST_DUMMY: begin
                cur_nxt.st = sse_pkg::SSE_ST_IDLE;
            end
            default: begin
                cur_nxt.st = sse_pkg::SSE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur_r <= '{st: sse_pkg::SSE_ST_IDLE, acc: sse_pkg::ACC_RESET, wdata: sse_pkg::ZERO,
                       default: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign accumulator = cur_r.acc;
    assign mem_we = cur_r.we;
    assign mem_wdata = cur_r.wdata;
    assign skip = cur_r.skip;
    assign dummy = cur_r.dum;
    assign busy = cur_r.busy;
    assign overflow_flag = cur_r.ov;
    assign zero_flag = cur_r.z;
    assign aux_carry_flag = cur_r.ac;
    assign carry_flag = cur_r.c;
    assign signed_compare_flag = cur_r.sc;
    assign combined_zero_flag = cur_r.cz;

    sequence s_skip_issue;
        accept && (op == sse_pkg::SSE_OP_INC_SKIP_ACC || op == sse_pkg::SSE_OP_SKIP_BIT
                   || op == sse_pkg::SSE_OP_SKIP_NONZERO);
    endsequence

    sequence s_two_cycles;
        busy ##1 !busy;
    endsequence

    a_inc_skip_acc: assert property (@(posedge core_clk) disable iff (rst) // RL1
        accept && op == sse_pkg::SSE_OP_INC_SKIP_ACC |=> accumulator == $past(mem_rdata) + 8'h01
        && skip == ($past(mem_rdata) == 8'hFF))
        else $error("increment skip result wrong");

    a_inc_no_write: assert property (@(posedge core_clk) disable iff (rst) // RL2
        accept && op == sse_pkg::SSE_OP_INC_SKIP_ACC |=> !mem_we)
        else $error("increment skip wrote memory");

    a_bit_skip: assert property (@(posedge core_clk) disable iff (rst) // RL3
        accept && op == sse_pkg::SSE_OP_SKIP_BIT |=> skip == $past(mem_rdata[bit_sel]))
        else $error("bit skip decision wrong");

    a_skip_two_cycles: assert property (@(posedge core_clk) disable iff (rst) // RL4
        s_skip_issue |=> s_two_cycles)
        else $error("skip not two cycles");

    a_nonzero_wb: assert property (@(posedge core_clk) disable iff (rst) // RL5
        accept && op == sse_pkg::SSE_OP_SKIP_NONZERO |=> mem_we
        && mem_wdata == $past(mem_rdata) && skip == ($past(mem_rdata) != 8'h00))
        else $error("nonzero skip wrong");

    a_sub_acc: assert property (@(posedge core_clk) disable iff (rst) // RL6
        accept && op == sse_pkg::SSE_OP_SUB_ACC |=> accumulator == $past(accumulator) - $past(mem_rdata))
        else $error("subtract to acc wrong");

    a_sub_carry: assert property (@(posedge core_clk) disable iff (rst) // RL7
        accept && is_sub(op) |=> carry_flag == ($past(accumulator) >= $past(sub_b)))
        else $error("carry after subtract wrong");

    a_sub_mem: assert property (@(posedge core_clk) disable iff (rst) // RL8
        accept && op == sse_pkg::SSE_OP_SUB_MEM |=> mem_we && $stable(accumulator)
        && mem_wdata == $past(accumulator) - $past(mem_rdata))
        else $error("subtract to memory wrong");

    a_sub_imm: assert property (@(posedge core_clk) disable iff (rst) // RL9
        accept && op == sse_pkg::OP_SUB_IMM |=> accumulator == $past(accumulator) - $past(imm))
        else $error("subtract immediate wrong");

    a_skip_flags: assert property (@(posedge core_clk) disable iff (rst) // RL10
        s_skip_issue |=> $stable({carry_flag, zero_flag, overflow_flag, aux_carry_flag,
                                  signed_compare_flag, combined_zero_flag}))
        else $error("skip changed flags");

    a_zero_flag: assert property (@(posedge core_clk) disable iff (rst) // RL11
        accept && is_sub(op) |=> zero_flag == ($past(accumulator) == $past(sub_b)))
        else $error("zero flag wrong");
endmodule : sse_exec
`default_nettype wire

/* src/sse_pkg.sv */
// constants and types shared by the skip-and-subtract execution unit
package sse_pkg;
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int NIB_MSB = 3;
    localparam int SIGN_BIT = 7;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] ZERO = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [1:0] SKIP_CYCLES = 2'h2;

    // operation selects, one-hot coded on the op port (OP_SUB_IMM below is 5'h18, not one-hot)
    typedef enum logic [4:0] {
        SSE_OP_INC_SKIP_ACC = 5'h01,
        SSE_OP_SKIP_BIT = 5'h02,
        SSE_OP_SKIP_NONZERO = 5'h04,
        SSE_OP_SUB_ACC = 5'h08,
        SSE_OP_SUB_MEM = 5'h10
    } sse_op_e;

    localparam logic [4:0] OP_SUB_IMM = 5'h18;

    typedef enum logic [1:0] {
        SSE_ST_IDLE = 2'h1,
        SSE_ST_DUMMY = 2'h2
    } sse_state_e;
endpackage : sse_pkg

/* src/sse_sub_flags.sv */
// 8-bit subtractor with status flag generation
`timescale 1ns/10ps
`default_nettype none
module sse_sub_flags (
    input wire logic [7:0] minuend, // accumulator value
    input wire logic [7:0] subtrahend, // memory byte or immediate
    output logic [7:0] diff, // difference
    output logic carry, // 1 when no borrow
    output logic aux_carry, // 1 when no borrow out of low nibble
    output logic overflow, // signed overflow
    output logic zero, // difference is zero
    output logic signed_compare, // signed minuend >= subtrahend
    output logic combined_zero // zero of signed compare chain
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        full = {1'b0, minuend} - {1'b0, subtrahend};
        low = {1'b0, minuend[sse_pkg::NIB_MSB:0]} - {1'b0, subtrahend[sse_pkg::NIB_MSB:0]};
        diff = full[7:0];
        // borrow shows as carry cleared
        carry = ~full[8];
        aux_carry = ~low[4];
        overflow = (minuend[sse_pkg::SIGN_BIT] ^ subtrahend[sse_pkg::SIGN_BIT])
                   & (minuend[sse_pkg::SIGN_BIT] ^ full[sse_pkg::SIGN_BIT]);
        zero = (full[7:0] == sse_pkg::ZERO);
        signed_compare = ~(full[sse_pkg::SIGN_BIT] ^ overflow);
        combined_zero = zero;
    end
endmodule : sse_sub_flags
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the skip-and-subtract execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk, rst, issue, mem_we, skip, dummy, busy;
    logic [4:0] op;
    logic [7:0] mem_rdata, imm, accumulator, mem_wdata, acc_m, m;
    logic [2:0] bit_sel;
    logic ov_f, z_f, ac_f, c_f, sc_f, cz_f;
    logic [5:0] flags, flg_m;
    logic [4:0] ops [6];
    int fail_count = 0;
    int checks = 0;

    assign flags = {ov_f, z_f, ac_f, c_f, sc_f, cz_f};

    sse_exec sse_exec_inst (
        .core_clk(core_clk), .rst(rst), .issue(issue), .op(op), .mem_rdata(mem_rdata),
        .imm(imm), .bit_sel(bit_sel), .accumulator(accumulator), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .skip(skip), .dummy(dummy), .busy(busy),
        .overflow_flag(ov_f), .zero_flag(z_f), .aux_carry_flag(ac_f), .carry_flag(c_f),
        .signed_compare_flag(sc_f), .combined_zero_flag(cz_f)
    );

    task automatic conclude;
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask : cmp_bit

    // order: overflow, zero, aux carry, carry, signed compare, combined zero
    function automatic logic [5:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        logic v;
        d = a - b;
        v = (a[7] != b[7]) && (d[7] != a[7]);
        return {v, d == 8'h00, a[3:0] >= b[3:0], a >= b, ~(d[7] ^ v), d == 8'h00};
    endfunction : sub_flags

    // entered just after a falling edge; leaves issue high for the caller to reuse
    task automatic run_op(input logic [4:0] o, input logic [7:0] md, input logic [7:0] x,
                          input logic [2:0] s);
        logic [7:0] b, e_acc, e_wd;
        logic e_we, e_skip, cls;
        b = (o == sse_pkg::OP_SUB_IMM) ? x : md;
        e_acc = acc_m;
        e_we = 1'b0;
        e_wd = 8'h00;
        e_skip = 1'b0;
        cls = o inside {5'h01, 5'h02, 5'h04};
        case (o)
            5'h01: begin
                e_acc = md + sse_pkg::ONE;
                e_skip = (e_acc == sse_pkg::ZERO);
            end
            5'h02: e_skip = md[s];
            5'h04: begin
                e_we = 1'b1;
                e_wd = md;
                e_skip = (md != sse_pkg::ZERO);
            end
            5'h10: begin
                e_we = 1'b1;
                e_wd = acc_m - md;
                flg_m = sub_flags(acc_m, md);
            end
            5'h08, sse_pkg::OP_SUB_IMM: begin
                e_acc = acc_m - b;
                flg_m = sub_flags(acc_m, b);
            end
            // undecoded codes keep acc and flags as they were; write strobe and skip stay low
            default: begin
            end
        endcase
        issue = 1'b1;
        op = o;
        mem_rdata = md;
        imm = x;
        bit_sel = s;
        @(negedge core_clk);
        acc_m = e_acc;
        cmp_byte(accumulator, e_acc);
        cmp_byte({2'h0, flags}, {2'h0, flg_m});
        cmp_bit(mem_we, e_we);
        cmp_byte(mem_wdata, e_wd);
        cmp_bit(skip, e_skip);
        cmp_bit(dummy, e_skip);
        cmp_bit(busy, cls);
        if (cls) begin
            // a request in the busy cycle must leave no trace
            op = sse_pkg::SSE_OP_SUB_ACC;
            mem_rdata = 8'($urandom);
            @(negedge core_clk);
            cmp_byte(accumulator, acc_m);
            cmp_bit(busy, 1'b0);
            cmp_bit(mem_we, 1'b0);
        end
    endtask : run_op

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // watchdog: the main sequence is far shorter than this
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        issue = 1'b0;
        op = sse_pkg::SSE_OP_SUB_ACC;
        mem_rdata = 8'h00;
        imm = 8'h00;
        bit_sel = 3'h0;
        acc_m = sse_pkg::ACC_RESET;
        flg_m = 6'h00;
        ops = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, sse_pkg::OP_SUB_IMM};
        void'($urandom(32'h2d891eda));
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        cmp_byte(accumulator, sse_pkg::ACC_RESET);
        cmp_byte({flags, busy, skip}, 8'h00);
        run_op(5'h01, 8'hFF, 8'h00, 3'h0);
        run_op(5'h01, 8'h7F, 8'h00, 3'h0);
        run_op(sse_pkg::OP_SUB_IMM, 8'h00, 8'h01, 3'h0);
        run_op(5'h08, 8'h7F, 8'h00, 3'h0);
        run_op(5'h10, 8'h00, 8'h00, 3'h0);
        run_op(5'h04, 8'h00, 8'h00, 3'h0);
        run_op(5'h04, 8'h80, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) begin
            run_op(5'h02, 8'h01 << i, 8'h00, 3'(i));
            run_op(5'h02, ~(8'h01 << i), 8'h00, 3'(i));
        end
        run_op(sse_pkg::OP_SUB_IMM, 8'h00, acc_m, 3'h0);
        run_op(5'h03, 8'h55, 8'h0F, 3'h1);
        for (int i = 0; i < 300; i++) begin
            m = 8'($urandom);
            run_op(ops[$urandom % 6], m, 8'($urandom), 3'($urandom));
        end
        issue = 1'b0;
        @(negedge core_clk);
        conclude();
    end
endmodule : testbench
`default_nettype wire
